// ### verilog/seecp_pkg.sv
// Purpose: constants for the serial eeprom command port
// Assumes: 100 MHz system clock
// Notes:   times are kept in their own unit, cycle counts derive from them
package seecp_pkg;
    localparam int          CLK_MHZ         = 100;
    localparam int          PROG_TIME_US    = 5000;
    localparam int          PROG_CYCLES     = PROG_TIME_US * CLK_MHZ;
    localparam int          MIN_SEL_LOW_NS  = 250;
    localparam int          MIN_SEL_LOW_CYC = (MIN_SEL_LOW_NS * CLK_MHZ
                                               + 999) / 1000;
    localparam int          PWRUP_DELAY_US  = 1000;
    localparam int          ARRAY_BYTES     = 256;
    localparam int          ADDR_BITS       = 8;
    localparam logic [1:0]  OP_EXT          = 2'h0;
    localparam logic [1:0]  OP_WRITE        = 2'h1;
    localparam logic [1:0]  OP_READ         = 2'h2;
    localparam logic [1:0]  OP_ERASE        = 2'h3;
    localparam logic [1:0]  EXT_LOCK        = 2'h0;
    localparam logic [1:0]  EXT_FILL        = 2'h1;
    localparam logic [1:0]  EXT_CLEAR       = 2'h2;
    localparam logic [1:0]  EXT_UNLOCK      = 2'h3;
    localparam logic [4:0]  HDR_BITS_W16    = 5'h0B;
    localparam logic [4:0]  HDR_BITS_W8     = 5'h0C;
    localparam logic [4:0]  DATA_BITS_W16   = 5'h10;
    localparam logic [4:0]  DATA_BITS_W8    = 5'h08;
    localparam logic        WEN_RESET       = 1'b0;
endpackage : seecp_pkg

// ### verilog/seecp_top.sv
// Purpose: device side of a 2048-bit serial eeprom command port
// Assumes: all input pins but i_reset asynchronous to i_mclk; serial clock far below 50 MHz
// Notes:   program cycle counted in i_mclk cycles; shorten via PROG_CYCLES
// Functional notes
// - instruction 11 bits x16, 12 bits x8
// - input sampled on serial clock rising edge
// - output high-z except read or status
// - status low while busy, high ready
// - shifted-in one releases status output once ready, not while busy
// - start bit, 2-bit opcode, address, data
// - opcodes 10 read, 11 erase, 01 write
// - opcode 00 decoded by two address bits
// - read: dummy zero then word msb first
// - read bits change on rising edge
// - sequential read increments, wraps to zero
// - dummy zero only before first word
// - start write-disabled, reject writes until unlock
// - write enable holds until lock command
// - reads work regardless of write enable
// - program cycle starts on select falling edge
// - write clears word before storing data
// - erase sets addressed word to ones
// - clear all sets every word ones
// - fill all stores data in every word
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
module seecp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             i_mclk,
    input  wire logic             i_reset,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;
    always_comb begin
        push        = i_in_valid && (count != (AW+1)'(DEPTH));
        pop         = i_out_ready && (count != '0);
        o_in_ready  = (count != (AW+1)'(DEPTH));
        o_out_valid = (count != '0);
        o_out_data  = mem[rd_ptr];
    end
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                mem[wr_ptr] <= i_in_data;
                wr_ptr      <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop)
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : seecp_fifo
////////////////////////////////////////////////////////////////////////////
module seecp_top #(
    parameter int PROG_CYCLES = seecp_pkg::PROG_CYCLES
) (
    input  wire logic i_mclk,
    input  wire logic i_reset,
    input  wire logic i_chip_select,
    input  wire logic i_serial_clock,
    input  wire logic i_serial_data_in,
    input  wire logic i_word_width_select,
    output logic      o_serial_data_out,
    output logic      o_serial_data_oe,
    output logic      o_busy
);
    typedef enum logic [2:0] {
        SEECP_IDLE, SEECP_HDR, SEECP_DATA, SEECP_READ, SEECP_ARMED,
        SEECP_DONE
    } seecp_state_t;
    typedef enum logic [1:0] {
        SEECP_P_NONE, SEECP_P_WORD, SEECP_P_ALL
    } seecp_prog_t;

    ////////////////////////////////////////////////////////////////////////
    // synchronisers: first stage read only by second stage
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic       sk_prev;
    always_ff @(posedge i_mclk) begin
        sync1   <= {i_chip_select, i_serial_clock, i_serial_data_in,
                    i_word_width_select};
        sync2   <= sync1;
        sk_prev <= sync2[2];
    end
    logic cs;
    logic di;
    logic w16;
    logic sk_rise;
    assign cs      = sync2[3];
    assign di      = sync2[1];
    assign w16     = sync2[0];
    assign sk_rise = sync2[2] && !sk_prev;

    ////////////////////////////////////////////////////////////////////////
    // array, byte addressed; x16 words are byte pairs, high byte first
    logic [7:0] mem [seecp_pkg::ARRAY_BYTES];

    function automatic logic [7:0] byte_idx(input logic [8:0] a,
                                            input logic w, input logic hi);
        byte_idx = w ? {a[6:0], ~hi} : a[7:0];
    endfunction : byte_idx

    ////////////////////////////////////////////////////////////////////////
    // command state
    seecp_state_t state, next_state;
    seecp_prog_t  prog, next_prog;
    logic [13:0]  shreg, next_shreg;
    logic [4:0]   cnt, next_cnt;
    logic [15:0]  wdata, next_wdata;
    logic [8:0]   addr, next_addr;
    logic [15:0]  rword, next_rword;
    logic         wen, next_wen;
    logic         dout, next_dout;
    logic         doe, next_doe;
    logic         fill, next_fill;
    logic [31:0]  ptimer, next_ptimer;
    logic         rd_req;
    logic [4:0]   hdr_len;
    logic [4:0]   dat_len;
    logic [1:0]   op;
    logic [8:0]   a_in;

    always_comb begin
        hdr_len = w16 ? seecp_pkg::HDR_BITS_W16 : seecp_pkg::HDR_BITS_W8;
        dat_len = w16 ? seecp_pkg::DATA_BITS_W16 : seecp_pkg::DATA_BITS_W8;
        // shreg holds bits after start: opcode then address, lsb newest
        op   = w16 ? shreg[9:8] : shreg[10:9];
        a_in = w16 ? {1'b0, shreg[7:0]} : shreg[8:0];
    end

    // fetch word from array at an address
    function automatic logic [15:0] fetch(input logic [8:0] a,
                                          input logic w);
        logic [7:0] hb;
        logic [7:0] lb;
        hb = mem[byte_idx(a, w, 1'b1)];
        lb = mem[byte_idx(a, w, 1'b0)];
        fetch = w ? {hb, lb} : {lb, 8'h00};
    endfunction : fetch

    always_comb begin
        next_state  = state;
        next_prog   = prog;
        next_shreg  = shreg;
        next_cnt    = cnt;
        next_wdata  = wdata;
        next_addr   = addr;
        next_rword  = rword;
        next_wen    = wen;
        next_dout   = dout;
        next_doe    = doe;
        next_fill   = fill;
        next_ptimer = (ptimer != 32'h0) ? ptimer - 32'h1 : ptimer;
        rd_req      = 1'b0;
        case (state)
            SEECP_IDLE: begin
                if (!cs) begin
                    next_doe = 1'b0;
                end else if (prog != SEECP_P_NONE) begin
                    next_doe  = 1'b1;
                    next_dout = 1'b0;
                end else if (sk_rise && di) begin
                    next_doe   = 1'b0;
                    next_state = SEECP_HDR;
                    next_cnt   = 5'h1;
                    next_shreg = '0;
                end
            end
            SEECP_HDR: begin
                if (!cs) begin
                    next_state = SEECP_IDLE;
                end else if (sk_rise) begin
                    next_shreg = {shreg[12:0], di};
                    next_cnt   = cnt + 5'h1;
                    if (cnt + 5'h1 == hdr_len) begin
                        next_cnt = 5'h0;
                        next_state = SEECP_IDLE;
                        next_addr  = w16 ? {1'b0, shreg[6:0], di}
                                         : {shreg[7:0], di};
                        case (w16 ? shreg[8:7] : shreg[9:8])
                            seecp_pkg::OP_READ: begin
                                next_rword = fetch(w16 ?
                                    {2'b0, shreg[5:0], di} :
                                    {shreg[7:0], di}, w16);
                                next_doe   = 1'b1;
                                next_dout  = 1'b0;
                                next_state = SEECP_READ;
                            end
                            seecp_pkg::OP_WRITE: begin
                                next_state = SEECP_DATA;
                                next_fill  = 1'b0;
                            end
                            seecp_pkg::OP_ERASE: begin
                                next_wdata = 16'hFFFF;
                                next_fill  = 1'b0;
                                next_state = wen ? SEECP_ARMED
                                                 : SEECP_DONE;
                            end
                            default: begin
                                case (w16 ? shreg[6:5] : shreg[7:6])
                                    seecp_pkg::EXT_UNLOCK:
                                        next_wen = 1'b1;
                                    seecp_pkg::EXT_LOCK:
                                        next_wen = 1'b0;
                                    seecp_pkg::EXT_CLEAR: begin
                                        next_wdata = 16'hFFFF;
                                        next_fill  = 1'b1;
                                        next_state = wen ? SEECP_ARMED
                                                         : SEECP_DONE;
                                    end
                                    default: begin
                                        next_fill  = 1'b1;
                                        next_state = SEECP_DATA;
                                    end
                                endcase
                                if (next_state == SEECP_IDLE)
                                    next_state = SEECP_DONE;
                            end
                        endcase
                    end
                end
            end
            SEECP_DATA: begin
                if (!cs) begin
                    next_state = SEECP_IDLE;
                end else if (sk_rise) begin
                    next_wdata = {wdata[14:0], di};
                    next_cnt   = cnt + 5'h1;
                    if (cnt + 5'h1 == dat_len)
                        next_state = wen ? SEECP_ARMED : SEECP_DONE;
                end
            end
            SEECP_READ: begin
                if (!cs) begin
                    next_doe   = 1'b0;
                    next_state = SEECP_IDLE;
                end else if (sk_rise) begin
                    next_dout  = rword[15];
                    next_rword = {rword[14:0], 1'b0};
                    next_cnt   = cnt + 5'h1;
                    if (cnt + 5'h1 == dat_len) begin
                        next_cnt   = 5'h0;
                        next_addr  = w16 ? {2'b0, addr[6:0] + 7'h1}
                                         : addr + 9'h1;
                        next_rword = fetch(next_addr, w16);
                    end
                end
            end
            SEECP_ARMED: begin
                if (!cs) begin
                    next_prog   = fill ? SEECP_P_ALL : SEECP_P_WORD;
                    next_ptimer = 32'(PROG_CYCLES);
                    next_state  = SEECP_IDLE;
                end
            end
            SEECP_DONE: begin
                if (!cs)
                    next_state = SEECP_IDLE;
            end
            default: next_state = SEECP_IDLE;
        endcase
        if (prog != SEECP_P_NONE && ptimer == 32'h1) begin
            next_prog = SEECP_P_NONE;
            if (cs && doe)
                next_dout = 1'b1;
        end
        if (state == SEECP_IDLE && prog == SEECP_P_NONE && cs && doe
            && !sk_rise)
            next_dout = 1'b1;
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            state  <= SEECP_IDLE;
            prog   <= SEECP_P_NONE;
            shreg  <= '0;
            cnt    <= '0;
            wdata  <= '0;
            addr   <= '0;
            rword  <= '0;
            wen    <= seecp_pkg::WEN_RESET;
            dout   <= 1'b0;
            doe    <= 1'b0;
            fill   <= 1'b0;
            ptimer <= '0;
        end else begin
            state  <= next_state;
            prog   <= next_prog;
            shreg  <= next_shreg;
            cnt    <= next_cnt;
            wdata  <= next_wdata;
            addr   <= next_addr;
            rword  <= next_rword;
            wen    <= next_wen;
            dout   <= next_dout;
            doe    <= next_doe;
            fill   <= next_fill;
            ptimer <= next_ptimer;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // program data passes a small fifo; array side drains one word per cycle
    logic        pf_ready;
    logic        pf_valid;
    logic [24:0] pf_data;
    logic        pf_push;
    assign pf_push = (state == SEECP_ARMED) && !cs && pf_ready;
    seecp_fifo #(.WIDTH(25), .DEPTH(4)) u_fifo (
        .i_mclk      (i_mclk),
        .i_reset     (i_reset),
        .i_in_valid  (pf_push),
        .o_in_ready  (pf_ready),
        .i_in_data   ({fill, addr[7:0], wdata}),
        .o_out_valid (pf_valid),
        .i_out_ready (1'b1),
        .o_out_data  (pf_data)
    );
    // whole word overwritten: clear and store in one step
    always_ff @(posedge i_mclk) begin
        if (pf_valid) begin
            for (int i = 0; i < seecp_pkg::ARRAY_BYTES; i++) begin
                if (pf_data[24]) begin
                    mem[i] <= (w16 && i[0] == 1'b0) ? pf_data[15:8]
                                                      : pf_data[7:0];
                end
            end
            if (!pf_data[24]) begin
                if (w16) begin
                    mem[byte_idx({1'b0, pf_data[23:16]}, 1'b1, 1'b1)]
                        <= pf_data[15:8];
                    mem[byte_idx({1'b0, pf_data[23:16]}, 1'b1, 1'b0)]
                        <= pf_data[7:0];
                end else begin
                    mem[pf_data[23:16]] <= pf_data[7:0];
                end
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_serial_data_out <= 1'b0;
            o_serial_data_oe  <= 1'b0;
            o_busy            <= 1'b0;
        end else begin
            o_serial_data_out <= next_dout;
            o_serial_data_oe  <= next_doe && cs;
            o_busy            <= (next_prog != SEECP_P_NONE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    AST_HIZ_DESEL: assert property (@(posedge i_mclk) disable iff (i_reset)
        !cs |=> !o_serial_data_oe) else $error("output driven deselected");
    AST_BUSY_LOW: assert property (@(posedge i_mclk) disable iff (i_reset)
        (prog != SEECP_P_NONE && cs && doe && ptimer > 32'h2)
        |=> !o_serial_data_out) else $error("busy not low");
    AST_LOCKED: assert property (@(posedge i_mclk) disable iff (i_reset)
        !wen |-> state != SEECP_ARMED) else $error("locked program");
    AST_START: assert property (@(posedge i_mclk) disable iff (i_reset)
        (state == SEECP_ARMED && !cs) |=> prog != SEECP_P_NONE)
        else $error("cycle not started");
    AST_NOCMD: assert property (@(posedge i_mclk) disable iff (i_reset)
        prog != SEECP_P_NONE |-> state != SEECP_HDR || $past(state) ==
        SEECP_HDR) else $error("cmd accepted busy");
    AST_ABANDON: assert property (@(posedge i_mclk) disable iff (i_reset)
        (!cs && (state == SEECP_HDR || state == SEECP_DATA))
        |=> state == SEECP_IDLE) else $error("not abandoned");
    AST_DUMMY: assert property (@(posedge i_mclk) disable iff (i_reset)
        (state == SEECP_HDR && next_state == SEECP_READ)
        |=> !dout && doe) else $error("no dummy zero");
    AST_WEN_HOLD: assert property (@(posedge i_mclk) disable iff (i_reset)
        (wen && state != SEECP_HDR) |=> wen) else $error("wen dropped");
endmodule : seecp_top

// ### bench/seecp_host.sv
// Purpose: host model that drives the serial command port pins
// Assumes: serial clock of 125 ns, made only inside frames
// Notes:   the bench calls its tasks; the data line toggles when unused
`timescale 1ns/1ns
module seecp_host #(
    parameter int PWRUP_NS = 1000
) (
    input  wire logic i_serial_data_out,
    input  wire logic i_serial_data_oe,
    output logic      o_chip_select,
    output logic      o_serial_clock,
    output logic      o_serial_data_in
);
////////////////////////////////////////////////////////////////////////////
    initial begin
        o_chip_select    = 1'b0;
        o_serial_clock   = 1'b0;
        o_serial_data_in = 1'b0;
    end
    // start-up wait kept short so the run stays small
    task automatic powerup();
        #(PWRUP_NS);
    endtask : powerup
    task automatic select();
        o_chip_select = 1'b1;
        #60;
    endtask : select
    // data set while the clock is low, taken at the rise
    task automatic xfer(input logic d, output logic q, output logic e);
        o_serial_data_in = d;
        #63 o_serial_clock = 1'b1;
        #62;
        q = i_serial_data_out;
        e = i_serial_data_oe;
        o_serial_clock = 1'b0;
    endtask : xfer
    task automatic deselect();
        o_serial_data_in = ~o_serial_data_in;
        o_chip_select    = 1'b0;
        #300;
    endtask : deselect
endmodule : seecp_host

// ### bench/seecp_top_bench.sv
// Purpose: self-checking bench for the serial eeprom command port
// Assumes: program cycle shortened to 400 system clocks
// Notes:   word model per organisation, rebuilt by a clear-all
`timescale 1ns/1ns
`define CHK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("ERROR %0t: got %0h expected %0h", $time, got, exp); \
        end \
    end
module seecp_top_bench;
    logic        i_mclk;
    logic        i_reset;
    logic        i_word_width_select;
    logic        cs, sk, di, dout, oe, busy;
    int          mismatches;
    int          comparisons;
    int          mem [256];
    logic        wen;
    logic [31:0] seed;
////////////////////////////////////////////////////////////////////////////
    seecp_top #(.PROG_CYCLES(400)) seecp_top_i (
        .i_mclk(i_mclk), .i_reset(i_reset), .i_chip_select(cs),
        .i_serial_clock(sk), .i_serial_data_in(di),
        .i_word_width_select(i_word_width_select),
        .o_serial_data_out(dout), .o_serial_data_oe(oe), .o_busy(busy));
    seecp_host seecp_host_i (
        .i_serial_data_out(dout), .i_serial_data_oe(oe),
        .o_chip_select(cs), .o_serial_clock(sk), .o_serial_data_in(di));

    always #5 i_mclk = ~i_mclk;

    function automatic int rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return int'(seed[15:0]);
    endfunction : rnd
    function automatic int abits();
        return i_word_width_select ? 8 : 9;
    endfunction : abits
    // lowest three address bits are random: they must be ignored
    function automatic int ext(input logic [1:0] c);
        return (int'(c) << (abits() - 2)) | (rnd() & 7);
    endfunction : ext

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results
    task automatic shift(input logic [31:0] v, input int n,
                         output logic [31:0] q, output logic e);
        logic b;
        q = 32'h0;
        for (int i = n - 1; i >= 0; i--) begin
            seecp_host_i.xfer(v[i], b, e);
            q = {q[30:0], b};
        end
    endtask : shift
    // top address bit comes from the caller's random value
    task automatic rd(input int a, input int n);
        int          db;
        int          nw;
        logic [31:0] q;
        logic        e;
        db = i_word_width_select ? 16 : 8;
        nw = i_word_width_select ? 128 : 256;
        seecp_host_i.select();
        shift((32'h6 << abits()) | (32'(a) & ((32'h1 << abits()) - 32'h1)),
              3 + abits(), q, e);
        `CHK(e, 1'b1)
        `CHK(q[0], 1'b0)
        for (int k = 0; k < n; k++) begin
            shift(32'h0, db, q, e);
            `CHK(q, 32'(mem[(a + k) % nw]))
        end
        seecp_host_i.deselect();
        `CHK(oe, 1'b0)
    endtask : rd
    task automatic prog(input logic [1:0] op, input int a, input int d);
        int          ab;
        int          nw;
        int          mask;
        int          x;
        logic [31:0] q;
        logic        e;
        logic        wr;
        ab   = abits();
        nw   = i_word_width_select ? 128 : 256;
        mask = i_word_width_select ? 32'h0000FFFF : 32'h000000FF;
        x    = (a >> (ab - 2)) & 3;
        wr   = (op != 2'h0) || x == 1 || x == 2;
        seecp_host_i.select();
        shift(((32'h4 | op) << ab) | a, 3 + ab, q, e);
        if (op == seecp_pkg::OP_WRITE || (op == 2'h0 && x == 1)) begin
            shift(32'(d), i_word_width_select ? 16 : 8, q, e);
        end
        seecp_host_i.deselect();
        `CHK(busy, wr & wen)
        if (wr && wen) begin
            if (op == seecp_pkg::OP_WRITE) mem[a % nw] = d & mask;
            if (op == seecp_pkg::OP_ERASE) mem[a % nw] = mask;
            for (int i = 0; i < nw; i++) begin
                if (op == 2'h0 && x == 2) mem[i] = mask;
                if (op == 2'h0 && x == 1) mem[i] = d & mask;
            end
            seecp_host_i.select();
            `CHK(oe, 1'b1)
            `CHK(dout, 1'b0)
            for (int n = 0; n < 100 && dout !== 1'b1; n++) #100;
            if (dout !== 1'b1) begin
                mismatches++;
                $display("ERROR %0t: program cycle never ended", $time);
                results();
            end
            `CHK(busy, 1'b0)
            seecp_host_i.xfer(1'b1, q[0], e);
            `CHK(e, 1'b0)
            seecp_host_i.deselect();
        end
        if (op == 2'h0 && x == 3) wen = 1'b1;
        if (op == 2'h0 && x == 0) wen = 1'b0;
    endtask : prog
    task automatic done(input string s);
        $display("test %s done at %0t", s, $time);
    endtask : done

    initial begin
        int          a;
        logic [31:0] q;
        logic        e;
        i_mclk = 1'b0;
        i_reset = 1'b1;
        i_word_width_select = 1'b1;
        seed = 32'h00017F21;
        mismatches = 0;
        comparisons = 0;
        wen = 1'b0;
        foreach (mem[i]) mem[i] = 0;
        repeat (3) @(posedge i_mclk);
        #1 i_reset = 1'b0;
        seecp_host_i.powerup();
        `CHK(oe, 1'b0)
        prog(seecp_pkg::OP_WRITE, rnd() % 256, rnd());
        done("locked");
        prog(2'h0, ext(seecp_pkg::EXT_UNLOCK), 0);
        prog(2'h0, ext(seecp_pkg::EXT_CLEAR), 0);
        rd(rnd(), 2);
        for (int i = 0; i < 4; i++) begin
            a = rnd() % 256;
            prog(seecp_pkg::OP_WRITE, a, rnd());
            rd(a, 1);
        end
        prog(seecp_pkg::OP_ERASE, a, 0);
        rd(a, 1);
        prog(seecp_pkg::OP_WRITE, 127, rnd());
        prog(seecp_pkg::OP_WRITE, 128, rnd());
        rd(255, 2);
        done("x16 words");
        prog(2'h0, ext(seecp_pkg::EXT_FILL), rnd());
        rd(rnd(), 3);
        prog(2'h0, ext(seecp_pkg::EXT_LOCK), 0);
        prog(seecp_pkg::OP_ERASE, 9, 0);
        rd(9, 1);
        seecp_host_i.select();
        shift(32'h6, 5, q, e);
        seecp_host_i.deselect();
        rd(4, 1);
        done("lock and abandon");
        @(posedge i_mclk);
        #1 i_word_width_select = 1'b0;
        prog(2'h0, ext(seecp_pkg::EXT_UNLOCK), 0);
        prog(2'h0, ext(seecp_pkg::EXT_CLEAR), 0);
        a = rnd() % 512;
        prog(seecp_pkg::OP_WRITE, a, rnd());
        rd(a, 2);
        prog(seecp_pkg::OP_WRITE, 255, rnd());
        rd(255, 2);
        done("x8 bytes");
        results();
    end
endmodule : seecp_top_bench
